// ### pkg/port_cfg_pkg.sv
// constants for the port direction and pull-up configuration block
package port_cfg_pkg;

  // ==========================================================
  // register byte addresses
  localparam logic [15:0] ADDR_P6_DIR = 16'hffe9;
  localparam logic [15:0] ADDR_P7_DIR = 16'hffea;
  localparam logic [15:0] ADDR_P8_DIR = 16'hffeb;
  localparam logic [15:0] ADDR_P9_DIR = 16'hffec;
  localparam logic [15:0] ADDR_P1_PU  = 16'hffed;
  localparam logic [15:0] ADDR_P3_PU  = 16'hffee;
  localparam logic [15:0] ADDR_P5_PU  = 16'hffef;

  // ==========================================================
  // values after reset
  localparam logic [7:0] RST_P6_DIR = 8'h00;
  localparam logic [7:0] RST_P7_DIR = 8'h00;
  localparam logic [7:0] RST_P8_DIR = 8'h00;
  localparam logic [7:0] RST_P9_DIR = 8'hc0;
  localparam logic [7:0] RST_P1_PU  = 8'h00;
  localparam logic [7:0] RST_P3_PU  = 8'h00;
  localparam logic [7:0] RST_P5_PU  = 8'h00;

  // ==========================================================
  // implemented bit positions of each register
  localparam logic [7:0] MASK_P6 = 8'hff;
  localparam logic [7:0] MASK_P7 = 8'hf8;
  localparam logic [7:0] MASK_P8 = 8'hff;
  localparam logic [7:0] MASK_P9 = 8'h1f;
  localparam logic [7:0] MASK_P1 = 8'hf1;
  localparam logic [7:0] MASK_P3 = 8'h07;
  localparam logic [7:0] MASK_P5 = 8'hff;

  // ==========================================================
  // read answers for locations that hold nothing readable, and the idle pin and read level
  localparam logic [7:0] RD_WRITE_ONLY = 8'hff;
  localparam logic [7:0] RD_UNMAPPED   = 8'hff;
  localparam logic [7:0] PIN_IDLE      = 8'h00;

  // ==========================================================
  // helpers
  function automatic logic [7:0] merge_bits(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic [7:0] mask);
    merge_bits = (old_v & ~mask) | (new_v & mask);
  endfunction

endpackage

// ### pkg/pin_ctl_if.sv
// per-port carrier between the register file and a pin stage
`timescale 1ns/100ps
interface pin_ctl_if;
  logic [7:0] cfg;      // direction or pull-up register bits
  logic [7:0] dir;      // direction bits of the port (pull-up use)
  logic [7:0] data;     // port data register bits
  logic       standby;  // chip in standby

  modport ctl (output cfg, output dir, output data, output standby);
  modport drv (input cfg, input dir, input data, input standby);
endinterface

// ### rtl/dir_pin_drive.sv
// output stage of one direction-controlled port
`timescale 1ns/100ps
module dir_pin_drive
  import port_cfg_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hff
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // control from the register file
  pin_ctl_if.drv          ctl,
  // pin drive
  output      logic [7:0] pin_out,
  output      logic [7:0] pin_oe
);

  // driver follows the data bits, enabled only for output pins
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out <= PIN_IDLE;
      pin_oe  <= PIN_IDLE;
    end else begin
      pin_out <= ctl.data & MASK;
      pin_oe  <= ctl.standby ? PIN_IDLE : (ctl.cfg & MASK);
    end
  end

endmodule

// ### rtl/pullup_drive.sv
// pull-up control stage of one port
`timescale 1ns/100ps
module pullup_drive
  import port_cfg_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hff
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // control from the register file
  pin_ctl_if.drv          ctl,
  // pull-up and standby hold
  output      logic [7:0] pull_on,
  output      logic [7:0] hold_high
);

  // pull-up acts on input pins only; in standby it holds the pin high
  always_ff @(posedge clk) begin
    if (rst) begin
      pull_on   <= PIN_IDLE;
      hold_high <= PIN_IDLE;
    end else begin
      pull_on   <= ctl.cfg & MASK & ~ctl.dir;
      hold_high <= ctl.standby ? (ctl.cfg & MASK & ~ctl.dir) : PIN_IDLE;
    end
  end

endmodule

// ### rtl/port_direction_pullup_config.sv
// port direction and pull-up configuration registers with pin stages
//
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
module port_direction_pullup_config
  import port_cfg_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // register port
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output      logic [7:0]  rd_data,
  // chip state
  input  wire logic        standby,
  // port data register bits
  input  wire logic [7:0]  port6_data,
  input  wire logic [7:0]  port7_data,
  input  wire logic [7:0]  port8_data,
  input  wire logic [7:0]  port9_data,
  // direction of the pull-up ports
  input  wire logic [7:0]  port1_dir,
  input  wire logic [7:0]  port3_dir,
  input  wire logic [7:0]  port5_dir,
  // port 6 to 9 pin drive
  output      logic [7:0]  port6_out,
  output      logic [7:0]  port6_oe,
  output      logic [7:0]  port7_out,
  output      logic [7:0]  port7_oe,
  output      logic [7:0]  port8_out,
  output      logic [7:0]  port8_oe,
  output      logic [7:0]  port9_out,
  output      logic [7:0]  port9_oe,
  // pull-up state of ports 1, 3, 5
  output      logic [7:0]  port1_pull_on,
  output      logic [7:0]  port1_hold_high,
  output      logic [7:0]  port3_pull_on,
  output      logic [7:0]  port3_hold_high,
  output      logic [7:0]  port5_pull_on,
  output      logic [7:0]  port5_hold_high
);

  // ==========================================================
  // register storage
  logic [7:0] p6_dir_q;
  logic [7:0] p7_dir_q;
  logic [7:0] p8_dir_q;
  logic [7:0] p9_dir_q;
  logic [7:0] p1_pu_q;
  logic [7:0] p3_pu_q;
  logic [7:0] p5_pu_q;
  logic [7:0] rd_data_d;

  pin_ctl_if c6 ();
  pin_ctl_if c7 ();
  pin_ctl_if c8 ();
  pin_ctl_if c9 ();
  pin_ctl_if c1 ();
  pin_ctl_if c3 ();
  pin_ctl_if c5 ();

  // direction registers; reset clears ports 6 to 8 and loads port 9 with RST_P9_DIR
  always_ff @(posedge clk) begin
    if (rst) begin
      p6_dir_q <= RST_P6_DIR;
      p7_dir_q <= RST_P7_DIR;
      p8_dir_q <= RST_P8_DIR;
      p9_dir_q <= RST_P9_DIR;
    end else if (wr_en) begin
      if (addr == ADDR_P6_DIR) begin
        p6_dir_q <= merge_bits(p6_dir_q, wr_data, MASK_P6);
      end
      if (addr == ADDR_P7_DIR) begin
        p7_dir_q <= merge_bits(p7_dir_q, wr_data, MASK_P7);
      end
      if (addr == ADDR_P8_DIR) begin
        p8_dir_q <= merge_bits(p8_dir_q, wr_data, MASK_P8);
      end
      if (addr == ADDR_P9_DIR) begin
        p9_dir_q <= merge_bits(p9_dir_q, wr_data, MASK_P9);
      end
    end
  end

  // pull-up registers, reserved bits stay zero
  always_ff @(posedge clk) begin
    if (rst) begin
      p1_pu_q <= RST_P1_PU;
      p3_pu_q <= RST_P3_PU;
      p5_pu_q <= RST_P5_PU;
    end else if (wr_en) begin
      if (addr == ADDR_P1_PU) begin
        p1_pu_q <= merge_bits(p1_pu_q, wr_data, MASK_P1);
      end
      if (addr == ADDR_P3_PU) begin
        p3_pu_q <= merge_bits(p3_pu_q, wr_data, MASK_P3);
      end
      if (addr == ADDR_P5_PU) begin
        p5_pu_q <= merge_bits(p5_pu_q, wr_data, MASK_P5);
      end
    end
  end

  // ==========================================================
  // read path; direction locations never return their contents
  always_comb begin
    case (addr)
      ADDR_P6_DIR: rd_data_d = RD_WRITE_ONLY;
      ADDR_P7_DIR: rd_data_d = RD_WRITE_ONLY;
      ADDR_P8_DIR: rd_data_d = RD_WRITE_ONLY;
      ADDR_P9_DIR: rd_data_d = RD_WRITE_ONLY;
      ADDR_P1_PU:  rd_data_d = p1_pu_q;
      ADDR_P3_PU:  rd_data_d = p3_pu_q;
      ADDR_P5_PU:  rd_data_d = p5_pu_q;
      default:     rd_data_d = RD_UNMAPPED;
    endcase
  end

  // read data stands one cycle after the strobe only
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= PIN_IDLE;
    end else if (rd_en) begin
      rd_data <= rd_data_d;
    end else begin
      rd_data <= PIN_IDLE;
    end
  end

  // ==========================================================
  // carriers to the pin stages
  assign c6.cfg     = p6_dir_q;
  assign c6.dir     = p6_dir_q;
  assign c6.data    = port6_data;
  assign c6.standby = standby;
  assign c7.cfg     = p7_dir_q;
  assign c7.dir     = p7_dir_q;
  assign c7.data    = port7_data;
  assign c7.standby = standby;
  assign c8.cfg     = p8_dir_q;
  assign c8.dir     = p8_dir_q;
  assign c8.data    = port8_data;
  assign c8.standby = standby;
  assign c9.cfg     = p9_dir_q;
  assign c9.dir     = p9_dir_q;
  assign c9.data    = port9_data;
  assign c9.standby = standby;
  assign c1.cfg     = p1_pu_q;
  assign c1.dir     = port1_dir;
  assign c1.data    = PIN_IDLE;
  assign c1.standby = standby;
  assign c3.cfg     = p3_pu_q;
  assign c3.dir     = port3_dir;
  assign c3.data    = PIN_IDLE;
  assign c3.standby = standby;
  assign c5.cfg     = p5_pu_q;
  assign c5.dir     = port5_dir;
  assign c5.data    = PIN_IDLE;
  assign c5.standby = standby;

  // direction-controlled pin stages
  dir_pin_drive #(.MASK(MASK_P6)) u_p6 (
    .clk(clk), .rst(rst), .ctl(c6.drv), .pin_out(port6_out), .pin_oe(port6_oe)
  );
  dir_pin_drive #(.MASK(MASK_P7)) u_p7 (
    .clk(clk), .rst(rst), .ctl(c7.drv), .pin_out(port7_out), .pin_oe(port7_oe)
  );
  dir_pin_drive #(.MASK(MASK_P8)) u_p8 (
    .clk(clk), .rst(rst), .ctl(c8.drv), .pin_out(port8_out), .pin_oe(port8_oe)
  );
  dir_pin_drive #(.MASK(MASK_P9)) u_p9 (
    .clk(clk), .rst(rst), .ctl(c9.drv), .pin_out(port9_out), .pin_oe(port9_oe)
  );

  // pull-up stages
  pullup_drive #(.MASK(MASK_P1)) u_pu1 (
    .clk(clk), .rst(rst), .ctl(c1.drv),
    .pull_on(port1_pull_on), .hold_high(port1_hold_high)
  );
  pullup_drive #(.MASK(MASK_P3)) u_pu3 (
    .clk(clk), .rst(rst), .ctl(c3.drv),
    .pull_on(port3_pull_on), .hold_high(port3_hold_high)
  );
  pullup_drive #(.MASK(MASK_P5)) u_pu5 (
    .clk(clk), .rst(rst), .ctl(c5.drv),
    .pull_on(port5_pull_on), .hold_high(port5_hold_high)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // written direction reaches the driver enable two edges later
  a_p6_dir_enable: assert property (
    (wr_en && addr == ADDR_P6_DIR) ##1 !standby |=> port6_oe == $past(wr_data, 2))
    else $error("port 6 enable does not follow written direction");

  // all eight port 8 bits are implemented
  a_p8_full_byte: assert property (
    (wr_en && addr == ADDR_P8_DIR) ##1 !standby |=> port8_oe == $past(wr_data, 2))
    else $error("port 8 enable does not follow all eight bits");

  // unused port 7 and port 9 bits never drive
  a_p9_upper_off: assert property (
    port9_oe[7:5] == 3'h0 && port9_out[7:5] == 3'h0)
    else $error("port 9 unused bit driven");

  a_p7_lower_off: assert property (
    port7_oe[2:0] == 3'h0)
    else $error("port 7 unused bit driven");

  // direction reads return the fixed pattern
  a_dir_no_read: assert property (
    rd_en && addr >= ADDR_P6_DIR && addr <= ADDR_P9_DIR |=> rd_data == RD_WRITE_ONLY)
    else $error("direction register read back");

  // reset leaves every direction pin an input
  a_reset_inputs: assert property (disable iff (1'b0)
    rst ##1 rst |-> port6_oe == 8'h00 && port7_oe == 8'h00 && port8_oe == 8'h00
                    && port9_oe == 8'h00)
    else $error("pin enabled after reset");

  // port 1 pull-up reads back what was written, reserved bits zero
  a_p1_readback: assert property (
    (wr_en && addr == ADDR_P1_PU) ##1 (rd_en && addr == ADDR_P1_PU)
      |=> rd_data == ($past(wr_data, 2) & MASK_P1))
    else $error("port 1 pull-up read mismatch");

  // output data follows the data register, gated by direction
  a_p8_data_drive: assert property (
    !standby |=> port8_out == $past(port8_data) && port8_oe == $past(p8_dir_q))
    else $error("port 8 drive does not follow data and direction");

  // standby releases the port 6, 8 and 9 direction-controlled drivers
  a_standby_float: assert property (
    standby |=> port6_oe == 8'h00 && port8_oe == 8'h00 && port9_oe == 8'h00)
    else $error("pin driven in standby");

  // enabled pull-up on an input pin holds high in standby
  a_pullup_hold: assert property (
    standby && p1_pu_q[0] && !port1_dir[0] |=> port1_hold_high[0])
    else $error("pull-up did not hold pin high in standby");

  // port 7 enable follows the five implemented written bits
  a_p7_dir_enable: assert property (
    (wr_en && addr == ADDR_P7_DIR) ##1 !standby
      |=> port7_oe == ($past(wr_data, 2) & MASK_P7))
    else $error("port 7 enable does not follow written direction");

  // port 9 enable follows only bits 4 to 0
  a_p9_dir_enable: assert property (
    (wr_en && addr == ADDR_P9_DIR) ##1 !standby
      |=> port9_oe == ($past(wr_data, 2) & MASK_P9))
    else $error("port 9 enable does not follow written direction");

  // port 6 pins follow their data bits one edge later
  a_p6_data_drive: assert property (
    !standby |=> port6_out == $past(port6_data) && port6_oe == $past(p6_dir_q))
    else $error("port 6 drive does not follow data and direction");

  // port 6 to 8 direction registers and port 9 bits 4 to 0 are cleared by reset
  a_dir_reset_clear: assert property (disable iff (1'b0)
    rst |=> p6_dir_q == 8'h00 && p7_dir_q == 8'h00 && p8_dir_q == 8'h00
            && p9_dir_q[4:0] == 5'h00)
    else $error("direction register not cleared by reset");

  // port 9 comes out of reset with its top two bits set
  a_p9_reset_pattern: assert property (disable iff (1'b0)
    rst |=> p9_dir_q == RST_P9_DIR)
    else $error("port 9 direction reset pattern wrong");

  // unused port 1 pull-up bits read as zero
  a_p1_reserved_zero: assert property (
    rd_en && addr == ADDR_P1_PU |=> rd_data[3:1] == 3'h0)
    else $error("port 1 reserved pull-up bit read as one");

  // port 1 pull-up acts one edge after the register and pin direction
  a_p1_pull_follow: assert property (
    port1_pull_on == ($past(p1_pu_q) & ~$past(port1_dir)))
    else $error("port 1 pull-up does not follow its register");

  // ports 3 and 5 hold their enabled input pins high in standby
  a_hold_ports35: assert property (
    standby |=> port3_hold_high == ($past(p3_pu_q) & ~$past(port3_dir))
                && port5_hold_high == ($past(p5_pu_q) & ~$past(port5_dir)))
    else $error("port 3 or 5 pull-up did not hold pin high in standby");

  // main scenarios reached
  c_p8_output: cover property ((wr_en && addr == ADDR_P8_DIR) ##2 port8_oe != 8'h00);
  c_p1_read: cover property (rd_en && addr == ADDR_P1_PU ##1 rd_data != 8'h00);
  c_standby_hold: cover property (standby ##1 port5_hold_high != 8'h00);
  c_p9_output: cover property ((wr_en && addr == ADDR_P9_DIR) ##2 port9_oe != 8'h00);
  c_dir_read: cover property (rd_en && addr == ADDR_P9_DIR ##1 rd_data == RD_WRITE_ONLY);

endmodule

// ### sim/tb_top.sv
// self-checking bench for the port direction and pull-up configuration block
`timescale 1ns/100ps
module tb_top;
  import port_cfg_pkg::*;

  // ==========================================================
  // stimulus and observed signals
  logic        clk         = 1'b0;
  logic        rst         = 1'b1;
  logic [15:0] addr        = 16'h0000;
  logic [7:0]  wr_data     = 8'h00;
  logic        wr_en       = 1'b0;
  logic        rd_en       = 1'b0;
  logic        standby     = 1'b0;
  logic [7:0]  d6 = 8'hff, d7 = 8'hff, d8 = 8'hff, d9 = 8'hff;
  logic [7:0]  r1 = 8'h00, r3 = 8'h00, r5 = 8'h00;
  logic [7:0]  rd_data;
  logic [7:0]  o6, e6, o7, e7, o8, e8, o9, e9;
  logic [7:0]  pu1, hh1, pu3, hh3, pu5, hh5;
  int          n_mismatch  = 0;
  int          check_count = 0;
  int          cycles      = 0;

  // register rows: address, write value, expected read back
  typedef struct {logic [15:0] a; logic [7:0] w; logic [7:0] e;} row_t;
  row_t rows [10] = '{
    '{16'hffed, 8'hff, 8'hf1}, '{16'hffed, 8'h0e, 8'h00}, '{16'hffee, 8'hff, 8'h07},
    '{16'hffef, 8'ha5, 8'ha5}, '{16'hffe9, 8'h3c, 8'hff}, '{16'hffea, 8'hff, 8'hff},
    '{16'hffeb, 8'h81, 8'hff}, '{16'hffec, 8'hff, 8'hff}, '{16'hffe8, 8'h55, 8'hff},
    '{16'h0000, 8'haa, 8'hff}};

  port_direction_pullup_config dut (
    .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .standby(standby),
    .port6_data(d6), .port7_data(d7), .port8_data(d8), .port9_data(d9),
    .port1_dir(r1), .port3_dir(r3), .port5_dir(r5),
    .port6_out(o6), .port6_oe(e6), .port7_out(o7), .port7_oe(e7),
    .port8_out(o8), .port8_oe(e8), .port9_out(o9), .port9_oe(e9),
    .port1_pull_on(pu1), .port1_hold_high(hh1), .port3_pull_on(pu3),
    .port3_hold_high(hh3), .port5_pull_on(pu5), .port5_hold_high(hh5));

  // ==========================================================
  // clock and hang guard
  always #2 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      $display("FAIL %0t run did not finish", $time);
      complete_run();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one bus cycle; strobes for the next cycle are set together
  task automatic acc(input logic is_wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= is_wr;
    rd_en   <= ~is_wr;
  endtask

  task automatic idle();
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    idle();
    #1;
    chk(rd_data, exp, "read data");
  endtask

  // let two edges pass so registered pin outputs follow
  task automatic settle();
    idle();
    @(posedge clk);
    #1;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(e6 | e7 | e8 | e9, 8'h00, "enables after reset");
    chk(pu1 | pu3 | pu5, 8'h00, "pull-ups after reset");
    rdchk(ADDR_P1_PU, 8'h00);
    // ordinary cases: write then read back to back
    foreach (rows[i]) begin
      acc(1'b1, rows[i].a, rows[i].w);
      rdchk(rows[i].a, rows[i].e);
    end
    $display("test register rows done");
    // read data stands for one cycle only
    rdchk(ADDR_P5_PU, 8'ha5);
    @(posedge clk);
    #1;
    chk(rd_data, 8'h00, "read data held too long");
    $display("test read strobe done");
    // direction bits drive enables, data drives pins
    acc(1'b1, ADDR_P6_DIR, 8'h0f);
    acc(1'b1, ADDR_P7_DIR, 8'hff);
    acc(1'b1, ADDR_P8_DIR, 8'ha5);
    acc(1'b1, ADDR_P9_DIR, 8'hff);
    settle();
    chk(e6, 8'h0f, "port6 enable");
    chk(e7, 8'hf8, "port7 enable");
    chk(e8, 8'ha5, "port8 enable");
    chk(e9, 8'h1f, "port9 enable");
    chk(o6, 8'hff, "port6 out");
    chk(o9, 8'h1f, "port9 out");
    @(posedge clk);
    d6 <= 8'h00;
    d7 <= 8'h00;
    d8 <= 8'h3c;
    d9 <= 8'h00;
    settle();
    chk(o6 | o7 | o9, 8'h00, "pins low");
    chk(o8, 8'h3c, "port8 out");
    acc(1'b1, ADDR_P8_DIR, 8'h00);
    settle();
    chk(e8, 8'h00, "port8 back to input");
    $display("test directions done");
    // pull-ups act on input pins, hold high in standby
    @(posedge clk);
    r1 <= 8'h10;
    r3 <= 8'h02;
    r5 <= 8'h0f;
    acc(1'b1, ADDR_P1_PU, 8'hff);
    acc(1'b1, ADDR_P3_PU, 8'hff);
    settle();
    chk(pu1, 8'he1, "port1 pull");
    chk(pu3, 8'h05, "port3 pull");
    chk(pu5, 8'ha0, "port5 pull");
    chk(hh1 | hh3 | hh5, 8'h00, "hold outside standby");
    @(posedge clk);
    standby <= 1'b1;
    settle();
    chk(hh1, 8'he1, "port1 hold");
    chk(hh3, 8'h05, "port3 hold");
    chk(hh5, 8'ha0, "port5 hold");
    chk(e6 | e7 | e9, 8'h00, "enables in standby");
    @(posedge clk);
    standby <= 1'b0;
    settle();
    chk(e6, 8'h0f, "port6 enable after standby");
    $display("test pull-ups done");
    // reset in mid-run turns direction pins back to inputs and clears pull-ups
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(e6 | e7 | e9, 8'h00, "enables after second reset");
    chk(pu1 | pu3 | pu5, 8'h00, "pull-ups after second reset");
    rdchk(ADDR_P1_PU, 8'h00);
    rdchk(ADDR_P9_DIR, 8'hff);
    settle();
    chk(e9, 8'h00, "port9 enable after reset");
    $display("test second reset done");
    complete_run();
  end
endmodule
